/* File: design/bpt_tx_ctrl.sv */
// Purpose: Broadcast parameter-group transmit control with AXI4-Lite registers
// Assumes: Network-side strobes and the end-of-scan tick are on clk_sys
// Notes: Bytes leave on a valid/ready stream; tx_pkt_last marks the end of each 8-byte packet
// Function
// - Receive timeout in 10 ms steps, zero disables
// - Send length bytes; zero means maximum length
// - Split payload over eight bytes into packets
// - Record requester address in reply destination word
// - Code 1 after multi-packet send, else 0
// - Code 10 when length exceeds maximum
// - Code 20 when transmit queue is full
// - Code 100 when multi-packet send fails
// - Refuse with 200 while local address unconfirmed
// - Refuse a reply with 201 while destination unconfirmed
// - Request flag set on request, cleared after reply
// - Event trigger sends at end of scan, then clears
// - Permitted global request records address, sets flag
// - Next end of scan sends reply to requester
// - Normal messages broadcast; replies addressed
`timescale 1ns/100ps
module bpt_tx_ctrl #(
  parameter int TICK_CYC = bpt_pkg::TICK_MS * bpt_pkg::CLK_KHZ
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic eos_tick,
  input wire logic local_addr_ok,
  input wire logic dest_addr_ok,
  input wire logic rx_frame,
  input wire logic [15:0] rx_pgn,
  input wire logic [7:0] rx_dest,
  input wire logic [7:0] rx_src,
  input wire logic [15:0] req_pgn,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic tx_last,
  output logic tx_pkt_last,
  output logic tx_multi,
  output logic [7:0] tx_dest,
  output logic tx_global,
  input wire logic q_pop,
  input wire logic tx_fail,
  output logic irq
);
  logic [15:0] transmit_length;
  logic [15:0] reply_destination_address;
  logic [15:0] transmit_result_code;
  logic req_pending;
  logic send_trigger_bit;
  logic reply_permission_flag;
  logic event_mode;
  logic [7:0] max_len;
  logic [15:0] rx_tmo;
  logic [15:0] tx_pgn_cfg;
  logic [bpt_pkg::IRQ_W-1:0] irq_stat;
  logic [bpt_pkg::IRQ_W-1:0] irq_mask;
  logic [31:0] data_mem [0:bpt_pkg::DATA_WORDS-1];
  bpt_pkg::bpt_state_t state;
  logic [7:0] eff_len;
  logic [7:0] byte_idx;
  logic reply_mode;
  logic last_multi;
  logic [2:0] q_cnt;
  // AXI write and read side
  logic aw_held, w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic [7:0] wr_idx;
  logic rd_go;
  logic [7:0] rd_idx;
  logic stat_read;
  // First byte address past the payload window; the window holds whole words
  localparam logic [11:0] DATA_END = bpt_pkg::DATA_BASE + 12'(4 * bpt_pkg::DATA_WORDS);

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction : merge16

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx = aw_addr[9:2];
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign rd_idx = s_axi_araddr[9:2];
  assign stat_read = rd_go && s_axi_araddr < bpt_pkg::DATA_BASE && rd_idx == bpt_pkg::IDX_IRQ_STAT;

  function automatic logic wr_to(input logic [7:0] idx);
    wr_to = wr_go && aw_addr < bpt_pkg::DATA_BASE && wr_idx == idx;
  endfunction : wr_to

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= bpt_pkg::AXI_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr >= bpt_pkg::DATA_BASE) begin
        s_axi_bresp <= (aw_addr < DATA_END) ? bpt_pkg::AXI_OKAY : bpt_pkg::AXI_SLVERR;
      end else begin
        s_axi_bresp <= (wr_idx <= bpt_pkg::IDX_TX_PGN) ? bpt_pkg::AXI_OKAY : bpt_pkg::AXI_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Payload storage; no reset, contents are software data
  always_ff @(posedge clk_sys) begin
    if (wr_go && aw_addr >= bpt_pkg::DATA_BASE && aw_addr < DATA_END) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb[b]) begin
          data_mem[aw_addr[7:2]][8*b +: 8] <= w_data[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= bpt_pkg::AXI_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= bpt_pkg::AXI_OKAY;
      s_axi_rdata <= 32'h00000000;
      if (s_axi_araddr >= bpt_pkg::DATA_BASE) begin
        if (s_axi_araddr < DATA_END) begin
          s_axi_rdata <= data_mem[s_axi_araddr[7:2]];
        end else begin
          s_axi_rresp <= bpt_pkg::AXI_SLVERR;
        end
      end else if (rd_idx == bpt_pkg::IDX_TX_LEN) begin
        s_axi_rdata <= {16'h0000, transmit_length};
      end else if (rd_idx == bpt_pkg::IDX_REPLY_DEST) begin
        s_axi_rdata <= {16'h0000, reply_destination_address};
      end else if (rd_idx == bpt_pkg::IDX_RESULT) begin
        s_axi_rdata <= {16'h0000, transmit_result_code};
      end else if (rd_idx == bpt_pkg::IDX_ACTION) begin
        s_axi_rdata <= {31'h00000000, req_pending};
      end else if (rd_idx == bpt_pkg::IDX_RSVD) begin
        s_axi_rdata <= 32'h00000000;
      end else if (rd_idx == bpt_pkg::IDX_CTRL) begin
        s_axi_rdata <= {29'h00000000, event_mode, reply_permission_flag, send_trigger_bit};
      end else if (rd_idx == bpt_pkg::IDX_MAX_LEN) begin
        s_axi_rdata <= {24'h000000, max_len};
      end else if (rd_idx == bpt_pkg::IDX_RX_TMO) begin
        s_axi_rdata <= {16'h0000, rx_tmo};
      end else if (rd_idx == bpt_pkg::IDX_IRQ_STAT) begin
        s_axi_rdata <= {28'h0000000, irq_stat};
      end else if (rd_idx == bpt_pkg::IDX_IRQ_MASK) begin
        s_axi_rdata <= {28'h0000000, irq_mask};
      end else if (rd_idx == bpt_pkg::IDX_TX_PGN) begin
        s_axi_rdata <= {16'h0000, tx_pgn_cfg};
      end else begin
        s_axi_rresp <= bpt_pkg::AXI_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      transmit_length <= 16'h0000;
      max_len <= bpt_pkg::RESET_MAX_LEN;
      rx_tmo <= 16'h0000;
      irq_mask <= '0;
      reply_permission_flag <= 1'b0;
      event_mode <= 1'b1;
      tx_pgn_cfg <= 16'h0000;
    end else begin
      if (wr_to(bpt_pkg::IDX_TX_LEN)) begin
        transmit_length <= merge16(transmit_length, w_data, w_strb);
      end
      // Larger values are clamped so the payload window cannot overrun
      if (wr_to(bpt_pkg::IDX_MAX_LEN) && w_strb[0]) begin
        max_len <= (w_data[7:0] > bpt_pkg::MAX_LEN_LIMIT) ? bpt_pkg::MAX_LEN_LIMIT
                                                          : w_data[7:0];
      end
      if (wr_to(bpt_pkg::IDX_RX_TMO)) begin
        rx_tmo <= merge16(rx_tmo, w_data, w_strb);
      end
      if (wr_to(bpt_pkg::IDX_IRQ_MASK) && w_strb[0]) begin
        irq_mask <= w_data[bpt_pkg::IRQ_W-1:0];
      end
      if (wr_to(bpt_pkg::IDX_CTRL) && w_strb[0]) begin
        reply_permission_flag <= w_data[bpt_pkg::CTRL_PERMIT];
        event_mode <= w_data[bpt_pkg::CTRL_EVENT];
      end
      if (wr_to(bpt_pkg::IDX_TX_PGN)) begin
        tx_pgn_cfg <= merge16(tx_pgn_cfg, w_data, w_strb);
      end
    end
  end

  // Scan-time decision
  logic [7:0] req_len;
  logic len_err;
  logic want_send;
  logic start_ok;
  logic tx_fire;
  logic tx_end;
  logic req_hit;
  logic [15:0] next_result;
  logic result_set;
  logic tmo_evt;

  assign req_len = (transmit_length == 16'h0000) ? max_len : transmit_length[7:0];
  assign len_err = transmit_length > {8'h00, max_len};
  assign want_send = eos_tick && state == bpt_pkg::ST_IDLE
                     && ((event_mode && send_trigger_bit) || req_pending);
  assign start_ok = want_send && local_addr_ok && (dest_addr_ok || !req_pending)
                    && !len_err && q_cnt != bpt_pkg::QDEPTH;
  assign tx_fire = tx_valid && tx_ready;
  assign tx_end = tx_fire && tx_last;
  assign req_hit = rx_frame && rx_pgn == bpt_pkg::REQ_PGN && rx_dest == bpt_pkg::GLOBAL_ADDR
                   && req_pgn == tx_pgn_cfg && reply_permission_flag;

  always_comb begin
    next_result = transmit_result_code;
    result_set = 1'b1;
    if (want_send && !local_addr_ok) begin
      next_result = bpt_pkg::RC_LOCAL_UNC;
    end else if (want_send && req_pending && !dest_addr_ok) begin
      next_result = bpt_pkg::RC_DEST_UNC;
    end else if (want_send && len_err) begin
      next_result = bpt_pkg::RC_LEN_ERR;
    end else if (want_send && q_cnt == bpt_pkg::QDEPTH) begin
      next_result = bpt_pkg::RC_Q_FULL;
    end else if (tx_end) begin
      next_result = last_multi ? bpt_pkg::RC_MULTI_DONE : bpt_pkg::RC_NORMAL;
    end else if (tx_fail && last_multi) begin
      next_result = bpt_pkg::RC_MULTI_FAIL;
    end else begin
      result_set = 1'b0;
    end
  end

  // Hardware codes win over a software clear in the same cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      transmit_result_code <= bpt_pkg::RC_NORMAL;
    end else if (result_set) begin
      transmit_result_code <= next_result;
    end else if (wr_to(bpt_pkg::IDX_RESULT)) begin
      transmit_result_code <= merge16(transmit_result_code, w_data, w_strb);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      send_trigger_bit <= 1'b0;
    end else if (wr_to(bpt_pkg::IDX_CTRL) && w_strb[0] && w_data[bpt_pkg::CTRL_TRIG]) begin
      send_trigger_bit <= 1'b1;
    end else if (tx_end && !reply_mode) begin
      send_trigger_bit <= 1'b0;
    end else if (wr_to(bpt_pkg::IDX_CTRL) && w_strb[0]) begin
      send_trigger_bit <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      req_pending <= 1'b0;
      reply_destination_address <= 16'h0000;
    end else begin
      if (req_hit) begin
        req_pending <= 1'b1;
        reply_destination_address <= {8'h00, rx_src};
      end else if (tx_end && reply_mode) begin
        req_pending <= 1'b0;
      end
    end
  end

  // Byte streamer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= bpt_pkg::ST_IDLE;
      eff_len <= 8'h00;
      byte_idx <= 8'h00;
      reply_mode <= 1'b0;
      last_multi <= 1'b0;
      tx_dest <= bpt_pkg::GLOBAL_ADDR;
      tx_global <= 1'b1;
    end else begin
      case (state)
        bpt_pkg::ST_IDLE: begin
          if (start_ok) begin
            state <= bpt_pkg::ST_SEND;
            eff_len <= req_len;
            byte_idx <= 8'h00;
            reply_mode <= req_pending;
            last_multi <= req_len > bpt_pkg::PKT_BYTES;
            tx_global <= !req_pending;
            tx_dest <= req_pending ? reply_destination_address[7:0]
                                   : bpt_pkg::GLOBAL_ADDR;
          end
        end
        bpt_pkg::ST_SEND: begin
          if (tx_end) begin
            state <= bpt_pkg::ST_IDLE;
          end else if (tx_fire) begin
            byte_idx <= byte_idx + 8'h01;
          end
        end
        default: state <= bpt_pkg::ST_IDLE;
      endcase
    end
  end

  always_comb begin
    tx_valid = state == bpt_pkg::ST_SEND;
    tx_last = tx_valid && byte_idx == eff_len - 8'h01;
    tx_pkt_last = tx_valid && (byte_idx[2:0] == 3'h7 || tx_last);
    tx_multi = last_multi;
    tx_data = data_mem[byte_idx[7:2]][8*byte_idx[1:0] +: 8];
  end

  // Messages handed to the link occupy a queue slot until popped
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q_cnt <= 3'h0;
    end else if (tx_end && !(q_pop && q_cnt != 3'h0)) begin
      q_cnt <= q_cnt + 3'h1;
    end else if (!tx_end && q_pop && q_cnt != 3'h0) begin
      q_cnt <= q_cnt - 3'h1;
    end
  end

  // Receive cycle monitor: 10 ms tick divider and step counter
  logic [$clog2(TICK_CYC)-1:0] div_cnt;
  logic tick;
  logic [15:0] tmo_cnt;
  assign tick = div_cnt == ($clog2(TICK_CYC))'(TICK_CYC - 1);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_cnt <= '0;
    end else if (tick || rx_frame) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tmo_cnt <= 16'h0000;
    end else if (rx_frame || rx_tmo == 16'h0000) begin
      tmo_cnt <= 16'h0000;
    end else if (tick && tmo_cnt != rx_tmo) begin
      tmo_cnt <= tmo_cnt + 16'h0001;
    end
  end
  // One event per elapsed window; a new frame rearms it
  assign tmo_evt = tick && rx_tmo != 16'h0000 && !rx_frame
                   && tmo_cnt == rx_tmo - 16'h0001;

  // Sticky interrupt status, cleared by reading; a new event wins
  logic [bpt_pkg::IRQ_W-1:0] evt;
  assign evt = {tmo_evt, req_hit, result_set && next_result != bpt_pkg::RC_NORMAL
                && next_result != bpt_pkg::RC_MULTI_DONE, tx_end};

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (stat_read ? '0 : irq_stat) | evt;
    end
  end
  assign irq = |(irq_stat & irq_mask);

  property p_len_zero;
    @(posedge clk_sys) disable iff (!rstn)
    (start_ok && transmit_length == 16'h0000) |=> (eff_len == max_len);
  endproperty
  a_len_zero: assert property (p_len_zero) else $error("zero length not max");

  property p_pkt_split;
    @(posedge clk_sys) disable iff (!rstn)
    (tx_fire && tx_pkt_last && !tx_last) |=> (tx_valid && byte_idx[2:0] == 3'h0);
  endproperty
  a_pkt_split: assert property (p_pkt_split) else $error("packet end missed");

  property p_code_local;
    @(posedge clk_sys) disable iff (!rstn)
    (want_send && !local_addr_ok) |=> (transmit_result_code == bpt_pkg::RC_LOCAL_UNC
                                       && state == bpt_pkg::ST_IDLE);
  endproperty
  a_code_local: assert property (p_code_local) else $error("code 200 missing");

  property p_code_dest;
    @(posedge clk_sys) disable iff (!rstn)
    (want_send && local_addr_ok && req_pending && !dest_addr_ok)
      |=> (transmit_result_code == bpt_pkg::RC_DEST_UNC && !tx_valid);
  endproperty
  a_code_dest: assert property (p_code_dest) else $error("code 201 missing");

  property p_code_len;
    @(posedge clk_sys) disable iff (!rstn)
    (want_send && local_addr_ok && (dest_addr_ok || !req_pending) && len_err)
      |=> transmit_result_code == bpt_pkg::RC_LEN_ERR;
  endproperty
  a_code_len: assert property (p_code_len) else $error("code 10 missing");

  property p_code_q;
    @(posedge clk_sys) disable iff (!rstn)
    (start_ok == 1'b0 && want_send && q_cnt == bpt_pkg::QDEPTH && local_addr_ok
     && (dest_addr_ok || !req_pending) && !len_err) |=> transmit_result_code == bpt_pkg::RC_Q_FULL;
  endproperty
  a_code_q: assert property (p_code_q) else $error("code 20 missing");

  property p_req_rec;
    @(posedge clk_sys) disable iff (!rstn)
    req_hit |=> (req_pending && reply_destination_address[7:0] == $past(rx_src));
  endproperty
  a_req_rec: assert property (p_req_rec) else $error("request not recorded");

  property p_dest_mode;
    @(posedge clk_sys) disable iff (!rstn)
    tx_valid |-> (tx_global == !reply_mode && (reply_mode || tx_dest == bpt_pkg::GLOBAL_ADDR));
  endproperty
  a_dest_mode: assert property (p_dest_mode) else $error("wrong destination");

  property p_multi_code;
    @(posedge clk_sys) disable iff (!rstn)
    (tx_end && eff_len > bpt_pkg::PKT_BYTES) |=> transmit_result_code == bpt_pkg::RC_MULTI_DONE;
  endproperty
  a_multi_code: assert property (p_multi_code) else $error("code 1 missing");

  property p_tmo_off;
    @(posedge clk_sys) disable iff (!rstn)
    (rx_tmo == 16'h0000) |-> !tmo_evt ##1 (tmo_cnt == 16'h0000);
  endproperty
  a_tmo_off: assert property (p_tmo_off) else $error("disabled timeout fired");
endmodule : bpt_tx_ctrl

/* File: design/bpt_pkg.sv */
// Purpose: Shared constants for the broadcast parameter-group transmit block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes: Printed offsets are word indices; byte address is four times the index
package bpt_pkg;
  // Register indices
  localparam logic [7:0] IDX_TX_LEN = 8'h00;
  localparam logic [7:0] IDX_REPLY_DEST = 8'h01;
  localparam logic [7:0] IDX_RESULT = 8'h02;
  localparam logic [7:0] IDX_ACTION = 8'h03;
  localparam logic [7:0] IDX_RSVD = 8'h04;
  localparam logic [7:0] IDX_CTRL = 8'h05;
  localparam logic [7:0] IDX_MAX_LEN = 8'h06;
  localparam logic [7:0] IDX_RX_TMO = 8'h07;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h08;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h09;
  localparam logic [7:0] IDX_TX_PGN = 8'h0a;
  // Payload storage window, one word holds four bytes, low byte first
  localparam logic [11:0] DATA_BASE = 12'h100;
  localparam int DATA_WORDS = 63;
  localparam logic [7:0] MAX_LEN_LIMIT = 8'hfc;
  localparam logic [7:0] PKT_BYTES = 8'h08;
  // Control register bits
  localparam int CTRL_TRIG = 0;
  localparam int CTRL_PERMIT = 1;
  localparam int CTRL_EVENT = 2;
  localparam int ACT_REQ = 0;
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_REQ = 2;
  localparam int IRQ_TMO = 3;
  localparam int IRQ_W = 4;
  // Result codes
  localparam logic [15:0] RC_NORMAL = 16'h0000;
  localparam logic [15:0] RC_MULTI_DONE = 16'h0001;
  localparam logic [15:0] RC_LEN_ERR = 16'h000a;
  localparam logic [15:0] RC_Q_FULL = 16'h0014;
  localparam logic [15:0] RC_MULTI_FAIL = 16'h0064;
  localparam logic [15:0] RC_LOCAL_UNC = 16'h00c8;
  localparam logic [15:0] RC_DEST_UNC = 16'h00c9;
  // Network constants
  localparam logic [15:0] REQ_PGN = 16'hea00;
  localparam logic [7:0] GLOBAL_ADDR = 8'hff;
  localparam logic [2:0] QDEPTH = 3'h4;
  localparam logic [7:0] RESET_MAX_LEN = 8'h08;
  // Timeout step and clock rate
  localparam int TICK_MS = 10;
  localparam int CLK_KHZ = 40000;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  typedef enum logic [0:0] {ST_IDLE, ST_SEND} bpt_state_t;
endpackage : bpt_pkg

/* File: verif/bpt_link_model.sv */
// Purpose: Link-side partner that takes bytes and frees queue slots
// Assumes: One clock; a byte moves on tx_valid and tx_ready high
// Notes: Stalls every other cycle so the sender must hold its byte
`timescale 1ns/100ps
module bpt_link_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic hold,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic tx_pkt_last,
  input wire logic tx_multi,
  output logic tx_ready,
  output logic q_pop,
  output logic [7:0] nbytes,
  output logic [7:0] last_byte,
  output logic [7:0] msgs,
  output logic [7:0] pkts,
  output logic multi
);
  logic [7:0] cnt;
  logic [7:0] pc;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_ready <= 1'b0;
      q_pop <= 1'b0;
      cnt <= 8'h00;
      nbytes <= 8'h00;
      last_byte <= 8'h00;
      msgs <= 8'h00;
      pc <= 8'h00;
      pkts <= 8'h00;
      multi <= 1'b0;
    end else begin
      tx_ready <= ~tx_ready;
      q_pop <= 1'b0;
      if (tx_valid && tx_ready) begin
        cnt <= cnt + 8'h01;
        if (tx_pkt_last) begin
          pc <= pc + 8'h01;
        end
        if (tx_last) begin
          pc <= 8'h00;
          pkts <= pc + 8'h01;
          multi <= tx_multi;
          // Holding back the pop lets the bench fill the queue
          cnt <= 8'h00;
          nbytes <= cnt + 8'h01;
          last_byte <= tx_data;
          msgs <= msgs + 8'h01;
          q_pop <= ~hold;
        end
      end
    end
  end
endmodule : bpt_link_model

/* File: verif/bpt_tx_ctrl_test.sv */
// Purpose: Self-checking bench for the parameter-group transmit block
// Assumes: AXI4-Lite master tasks; link partner model on the stream
// Notes: Short tick parameter keeps receive timeout windows a few cycles long
`timescale 1ns/100ps
module bpt_tx_ctrl_test;
  logic clk_sys, rstn, eos_tick, l_ok, d_ok, rx_frame, hold;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [15:0] rx_pgn, req_pgn;
  logic [7:0] rx_src, tx_data, tx_dest, nbytes, lastb, msgs, dst, pkts;
  logic tx_valid, tx_ready, tx_last, tx_global, q_pop, irq, g;
  logic tx_pkt_last, tx_multi, tx_fail, mlt;
  int error_cnt, checks_done;
  bpt_tx_ctrl #(.TICK_CYC(8)) bpt_tx_ctrl_inst (.clk_sys(clk_sys), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .eos_tick(eos_tick), .local_addr_ok(l_ok), .dest_addr_ok(d_ok), .rx_frame(rx_frame),
    .rx_pgn(rx_pgn), .rx_dest(8'hff), .rx_src(rx_src), .req_pgn(req_pgn),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_last(tx_last),
    .tx_pkt_last(tx_pkt_last), .tx_multi(tx_multi), .tx_dest(tx_dest), .tx_global(tx_global),
    .q_pop(q_pop), .tx_fail(tx_fail), .irq(irq));
  bpt_link_model bpt_link_model_inst (.clk_sys(clk_sys), .rstn(rstn), .hold(hold),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .tx_pkt_last(tx_pkt_last), .tx_multi(tx_multi), .pkts(pkts), .multi(mlt),
    .q_pop(q_pop), .nbytes(nbytes), .last_byte(lastb), .msgs(msgs));
  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ba
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk("rdata", rdata, exp);
    chk("rresp", 32'(rresp), 32'(er));
  endtask : rd
  task automatic go(input logic snd);
    logic [7:0] m0;
    m0 = msgs;
    eos_tick <= 1'b1;
    @(posedge clk_sys);
    eos_tick <= 1'b0;
    repeat (3) @(posedge clk_sys);
    while (snd && msgs === m0) begin
      if (tx_valid) begin
        g = tx_global;
        dst = tx_dest;
      end
      @(posedge clk_sys);
    end
    chk("sent", 32'(msgs - m0), 32'(snd));
  endtask : go
  task automatic t_send;
    wr(ba(bpt_pkg::IDX_RX_TMO), 32'h2);
    repeat (24) @(posedge clk_sys);
    rd(ba(bpt_pkg::IDX_IRQ_STAT), 32'h8, 2'b00);
    wr(ba(bpt_pkg::IDX_RX_TMO), 32'h0);
    repeat (24) @(posedge clk_sys);
    rd(ba(bpt_pkg::IDX_IRQ_STAT), 32'h0, 2'b00);
    wr(bpt_pkg::DATA_BASE, 32'h04030201);
    wr(bpt_pkg::DATA_BASE + 12'h4, 32'h08070605);
    wr(bpt_pkg::DATA_BASE + 12'h8, 32'h0c0b0a09);
    wr(ba(bpt_pkg::IDX_MAX_LEN), 32'h10);
    wr(ba(bpt_pkg::IDX_IRQ_MASK), 32'h1);
    wr(ba(bpt_pkg::IDX_TX_LEN), 32'h4);
    wr(ba(bpt_pkg::IDX_CTRL), 32'h5);
    go(1'b1);
    chk("bytes", 32'(nbytes), 32'h4);
    chk("last", 32'(lastb), 32'h4);
    chk("global", 32'(g), 32'h1);
    chk("pkts", 32'(pkts), 32'h1);
    chk("multi", 32'(mlt), 32'h0);
    rd(ba(bpt_pkg::IDX_RESULT), 32'(bpt_pkg::RC_NORMAL), 2'b00);
    rd(ba(bpt_pkg::IDX_CTRL), 32'h4, 2'b00);
    wr(ba(bpt_pkg::IDX_TX_LEN), 32'hc);
    wr(ba(bpt_pkg::IDX_CTRL), 32'h5);
    go(1'b1);
    chk("bytes", 32'(nbytes), 32'hc);
    chk("last", 32'(lastb), 32'hc);
    chk("pkts", 32'(pkts), 32'h2);
    chk("multi", 32'(mlt), 32'h1);
    chk("irq", 32'(irq), 32'h1);
    rd(ba(bpt_pkg::IDX_RESULT), 32'(bpt_pkg::RC_MULTI_DONE), 2'b00);
    rd(ba(bpt_pkg::IDX_IRQ_STAT), 32'h1, 2'b00);
    repeat (2) @(posedge clk_sys);
    chk("irq", 32'(irq), 32'h0);
    tx_fail <= 1'b1;
    @(posedge clk_sys);
    tx_fail <= 1'b0;
    rd(ba(bpt_pkg::IDX_RESULT), 32'(bpt_pkg::RC_MULTI_FAIL), 2'b00);
    wr(ba(bpt_pkg::IDX_RESULT), 32'h0);
    rd(ba(bpt_pkg::IDX_RESULT), 32'h0, 2'b00);
    rd(12'h0fc, 32'h0, bpt_pkg::AXI_SLVERR);
    $display("test send done");
  endtask : t_send
  task automatic t_refuse;
    wr(ba(bpt_pkg::IDX_TX_LEN), 32'h14);
    wr(ba(bpt_pkg::IDX_CTRL), 32'h5);
    go(1'b0);
    rd(ba(bpt_pkg::IDX_RESULT), 32'(bpt_pkg::RC_LEN_ERR), 2'b00);
    wr(ba(bpt_pkg::IDX_TX_LEN), 32'h0);
    l_ok <= 1'b0;
    go(1'b0);
    rd(ba(bpt_pkg::IDX_RESULT), 32'(bpt_pkg::RC_LOCAL_UNC), 2'b00);
    l_ok <= 1'b1;
    go(1'b1);
    chk("bytes", 32'(nbytes), 32'h10);
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_req;
    wr(ba(bpt_pkg::IDX_TX_PGN), 32'hfeca);
    wr(ba(bpt_pkg::IDX_CTRL), 32'h2);
    d_ok <= 1'b0;
    rx_pgn <= bpt_pkg::REQ_PGN;
    req_pgn <= 16'hfeca;
    rx_src <= 8'h21;
    rx_frame <= 1'b1;
    @(posedge clk_sys);
    rx_frame <= 1'b0;
    rd(ba(bpt_pkg::IDX_REPLY_DEST), 32'h21, 2'b00);
    rd(ba(bpt_pkg::IDX_ACTION), 32'h1, 2'b00);
    go(1'b0);
    rd(ba(bpt_pkg::IDX_RESULT), 32'(bpt_pkg::RC_DEST_UNC), 2'b00);
    d_ok <= 1'b1;
    go(1'b1);
    chk("dest", 32'(dst), 32'h21);
    chk("global", 32'(g), 32'h0);
    rd(ba(bpt_pkg::IDX_ACTION), 32'h0, 2'b00);
    $display("test request done");
  endtask : t_req
  task automatic t_queue;
    hold <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(ba(bpt_pkg::IDX_CTRL), 32'h5);
      go(i < 4);
    end
    rd(ba(bpt_pkg::IDX_RESULT), 32'(bpt_pkg::RC_Q_FULL), 2'b00);
    $display("test queue done");
  endtask : t_queue
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    // Long enough for every test with stalls and AXI overhead
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    end_sim();
  end
  initial begin
    {rstn, eos_tick, rx_frame, hold, awvalid, wvalid, arvalid, tx_fail} = '0;
    {l_ok, d_ok} = 2'b11;
    {awaddr, araddr, wdata, rx_pgn, req_pgn, rx_src} = '0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_send();
    t_refuse();
    t_req();
    t_queue();
    end_sim();
  end
endmodule : bpt_tx_ctrl_test
